// File: rtl/strap_boot_config_power_states.sv
// Contract
// - Straps are sampled at boot and fix address index and dead-battery policy before any load.
// - After sampling, configuration is read from EEPROM, else the block waits for a host load.
// - The EEPROM is addressed at 7-bit 0x50 and belongs to this device alone.
// - Pairs (7,5),(5,5),(2,0),(1,7) give indices 1-4 with always-sink; sink on, PD off until loaded.
// - Pairs (7,3),(3,3),(4,0),(3,7) give indices 1-4 with high-voltage; sink on, app mode, PD PHY on.
// - Pairs (7,0),(0,0),(6,0),(5,7) give indices 1-4 with no-sink; sink off, PD off until loaded.
// - Exactly one of Active, Idle, Sleep holds, changed automatically.
// - Active goes to Idle only after a quiet period; any activity restarts it.
// - Sleep still detects a Type-C attach and leaves on it.
// - Modern Standby is a variant of Idle, not a fourth state.
// - After boot the target port answers at base plus index minus one in the low two bits.
`timescale 1ns/100ps
`default_nettype none
`include "strap_boot_map.svh"

module strap_boot_config_power_states
   import strap_boot_pkg::*;
#(
   parameter int IDLE_CYCLES = `IDLE_TIME_US * `CLK_FREQ_MHZ
) (
   // Clock, reset, enable
   input  wire logic       clk_sys,
   input  wire logic       rstn,
   input  wire logic       clkEn,
   // Decoded strap values
   input  wire logic [2:0] strapValueA,
   input  wire logic [2:0] strapValueB,
   input  wire logic       strapValid,
   // Configuration controller port engine
   output logic            eepromReq,
   output logic [6:0]      eepromAddr,
   input  wire logic       eepromAck,
   input  wire logic       eepromNack,
   input  wire logic       eepromDone,
   input  wire logic       eepromFail,
   // Host target port
   input  wire logic       hostLoadDone,
   output logic [6:0]      targetAddr,
   output logic            targetAddrValid,
   // Boot status
   output logic [1:0]      policy,
   output logic [1:0]      addrIndex,
   output logic            strapInvalid,
   output logic            configLoaded,
   output logic            bootDone,
   output logic            applicationMode,
   output logic            pdEnable,
   // Activity and role
   input  wire logic       pdMsgIn,
   input  wire logic       ccChange,
   input  wire logic       gpioEvent,
   input  wire logic       i2cActivity,
   input  wire logic       voltageAlert,
   input  wire logic       faultAlert,
   input  wire logic       typecAttached,
   input  wire logic       standbyReq,
   input  wire logic       sourceRole,
   // Power state and paths
   output logic [1:0]      powerState,
   output logic            modernStandby,
   output logic            source5vPath,
   output logic            highVoltageSinkPath,
   output logic            externalSinkPath,
   output logic            cablePowerPath,
   output logic [1:0]      cc1Term,
   output logic [1:0]      cc2Term
);

   generate
      if (IDLE_CYCLES < 1) begin : g_bad
         $error("IDLE_CYCLES must be at least one");
      end
   endgenerate

   boot_state_type         boot_r;
   policy_type             policy_r;
   policy_type             policyNxt;
   logic [1:0]             index_r;
   logic [1:0]             indexNxt;
   logic                   invalidNxt;
   logic                   invalid_r;
   logic                   loaded_r;
   logic                   eeReq_r;
   logic                   sinkOn;
   logic                   srcOn;
   logic                   cableOn;
   cc_term_type            cc1Nxt;
   logic [5:0]             strapPair;

   pwr_link_if link ();

   assign strapPair       = {strapValueA, strapValueB};
   assign link.run        = (boot_r == BOOT_RUN);
   assign link.activity   = pdMsgIn | ccChange | gpioEvent | i2cActivity | voltageAlert | faultAlert;
   assign link.attached   = typecAttached;
   assign link.standbyReq = standbyReq;

   power_state_ctrl #(
      .IDLE_CYCLES (IDLE_CYCLES)
   ) u_pwr (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      .clkEn   (clkEn),
      .link    (link)
   );

   // Strap pair decode
   always_comb begin
      policyNxt  = POL_NO_SINK;
      indexNxt   = 2'h0;
      invalidNxt = 1'b0;
      case (strapPair)
         `STRAP_AS_IDX1: begin policyNxt = POL_ALWAYS_SINK;  indexNxt = 2'h0; end
         `STRAP_AS_IDX2: begin policyNxt = POL_ALWAYS_SINK;  indexNxt = 2'h1; end
         `STRAP_AS_IDX3: begin policyNxt = POL_ALWAYS_SINK;  indexNxt = 2'h2; end
         `STRAP_AS_IDX4: begin policyNxt = POL_ALWAYS_SINK;  indexNxt = 2'h3; end
         `STRAP_HV_IDX1: begin policyNxt = POL_HIGH_VOLTAGE; indexNxt = 2'h0; end
         `STRAP_HV_IDX2: begin policyNxt = POL_HIGH_VOLTAGE; indexNxt = 2'h1; end
         `STRAP_HV_IDX3: begin policyNxt = POL_HIGH_VOLTAGE; indexNxt = 2'h2; end
         `STRAP_HV_IDX4: begin policyNxt = POL_HIGH_VOLTAGE; indexNxt = 2'h3; end
         `STRAP_NS_IDX1: begin policyNxt = POL_NO_SINK;      indexNxt = 2'h0; end
         `STRAP_NS_IDX2: begin policyNxt = POL_NO_SINK;      indexNxt = 2'h1; end
         `STRAP_NS_IDX3: begin policyNxt = POL_NO_SINK;      indexNxt = 2'h2; end
         `STRAP_NS_IDX4: begin policyNxt = POL_NO_SINK;      indexNxt = 2'h3; end
         // Unlisted pair falls back to the harmless no-sink choice
         default:        invalidNxt = 1'b1;
      endcase
   end

   // Boot sequence
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         boot_r <= BOOT_SAMPLE;
      end else if (clkEn) begin
         case (boot_r)
            BOOT_SAMPLE: begin
               if (strapValid) begin
                  boot_r <= BOOT_EE_REQ;
               end
            end
            BOOT_EE_REQ: begin
               if (eepromNack) begin
                  boot_r <= BOOT_HOST_WAIT;
               end else if (eepromAck) begin
                  boot_r <= BOOT_EE_LOAD;
               end
            end
            BOOT_EE_LOAD: begin
               if (eepromDone) begin
                  boot_r <= BOOT_RUN;
               end else if (eepromFail) begin
                  boot_r <= BOOT_HOST_WAIT;
               end
            end
            BOOT_HOST_WAIT: begin
               if (hostLoadDone) begin
                  boot_r <= BOOT_RUN;
               end
            end
            BOOT_RUN: boot_r <= BOOT_RUN;
            default:  boot_r <= BOOT_SAMPLE;
         endcase
      end
   end

   // Strap capture, once, before any load
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         policy_r  <= POL_NO_SINK;
         index_r   <= 2'h0;
         invalid_r <= 1'b0;
      end else if (clkEn && boot_r == BOOT_SAMPLE && strapValid) begin
         policy_r  <= policyNxt;
         index_r   <= indexNxt;
         invalid_r <= invalidNxt;
      end
   end

   // EEPROM request holds until answered
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         eeReq_r    <= 1'b0;
         eepromAddr <= 7'h00;
      end else if (clkEn) begin
         eeReq_r    <= (boot_r == BOOT_EE_REQ) && !eepromAck && !eepromNack;
         eepromAddr <= `EEPROM_ADDR;
      end
   end
   assign eepromReq = eeReq_r;

   // Loaded flag never clears once set
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         loaded_r <= 1'b0;
      end else if (clkEn) begin
         if ((boot_r == BOOT_EE_LOAD && eepromDone) || (boot_r == BOOT_HOST_WAIT && hostLoadDone)) begin
            loaded_r <= 1'b1;
         end
      end
   end

   // Boot status outputs
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         policy          <= 2'h0;
         addrIndex       <= 2'h0;
         strapInvalid    <= 1'b0;
         configLoaded    <= 1'b0;
         bootDone        <= 1'b0;
         targetAddr      <= 7'h00;
         targetAddrValid <= 1'b0;
         applicationMode <= 1'b0;
         pdEnable        <= 1'b0;
      end else if (clkEn) begin
         policy          <= policy_r;
         addrIndex       <= index_r;
         strapInvalid    <= invalid_r;
         configLoaded    <= loaded_r;
         bootDone        <= (boot_r == BOOT_RUN);
         targetAddr      <= `TARGET_ADDR_BASE | {5'h00, index_r};
         targetAddrValid <= (boot_r == BOOT_RUN);
         // High-voltage policy runs the PHY without a loaded configuration
         applicationMode <= loaded_r || (boot_r != BOOT_SAMPLE && policy_r == POL_HIGH_VOLTAGE);
         pdEnable        <= loaded_r || (boot_r != BOOT_SAMPLE && policy_r == POL_HIGH_VOLTAGE);
      end
   end

   // Path selection by state and role
   always_comb begin
      sinkOn  = 1'b0;
      srcOn   = 1'b0;
      cableOn = 1'b0;
      cc1Nxt  = CC_OPEN;
      if (boot_r == BOOT_SAMPLE) begin
         sinkOn = 1'b0;
      end else if (!loaded_r) begin
         // Dead-battery behaviour until a configuration arrives
         sinkOn = (policy_r != POL_NO_SINK);
      end else begin
         case (link.state)
            PWR_ACTIVE, PWR_IDLE: begin
               srcOn   = sourceRole;
               sinkOn  = !sourceRole && !link.modernStandby;
               cableOn = !link.modernStandby;
               if (!link.modernStandby) begin
                  cc1Nxt = sourceRole ? CC_RD : CC_RP_3A0;
               end
            end
            PWR_SLEEP: begin
               srcOn  = 1'b0;
               sinkOn = 1'b0;
            end
            default: begin
               srcOn  = 1'b0;
               sinkOn = 1'b0;
            end
         endcase
      end
   end

   // Registered path and state outputs
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         powerState          <= 2'h0;
         modernStandby       <= 1'b0;
         source5vPath        <= 1'b0;
         highVoltageSinkPath <= 1'b0;
         externalSinkPath    <= 1'b0;
         cablePowerPath      <= 1'b0;
         cc1Term             <= 2'h0;
         cc2Term             <= 2'h0;
      end else if (clkEn) begin
         powerState          <= link.state;
         modernStandby       <= link.modernStandby;
         source5vPath        <= srcOn;
         highVoltageSinkPath <= sinkOn;
         externalSinkPath    <= sinkOn;
         cablePowerPath      <= cableOn;
         cc1Term             <= cc1Nxt;
         cc2Term             <= CC_OPEN;
      end
   end

endmodule

`default_nettype wire

// File: rtl/strap_boot_map.svh
`ifndef STRAP_BOOT_MAP_SVH
`define STRAP_BOOT_MAP_SVH

// Clock rate and idle period
`define CLK_FREQ_MHZ      25
`define IDLE_TIME_US      1000

// Configuration EEPROM address
`define EEPROM_ADDR       7'h50

// Target address: upper five bits fixed, index in low two
`define TARGET_ADDR_BASE  7'h20
`define TARGET_IDX_W      2

// Strap pairs as {A, B}, three bits each
`define STRAP_AS_IDX1     6'h3D
`define STRAP_AS_IDX2     6'h2D
`define STRAP_AS_IDX3     6'h10
`define STRAP_AS_IDX4     6'h0F
`define STRAP_HV_IDX1     6'h3B
`define STRAP_HV_IDX2     6'h1B
`define STRAP_HV_IDX3     6'h20
`define STRAP_HV_IDX4     6'h1F
`define STRAP_NS_IDX1     6'h38
`define STRAP_NS_IDX2     6'h00
`define STRAP_NS_IDX3     6'h30
`define STRAP_NS_IDX4     6'h2F

`endif

// File: rtl/strap_boot_pkg.sv
package strap_boot_pkg;

   typedef enum logic [1:0] {
      POL_ALWAYS_SINK,
      POL_HIGH_VOLTAGE,
      POL_NO_SINK
   } policy_type;

   typedef enum logic [1:0] {
      PWR_ACTIVE,
      PWR_IDLE,
      PWR_SLEEP
   } pwr_state_type;

   typedef enum logic [1:0] {
      CC_OPEN,
      CC_RD,
      CC_RP_3A0
   } cc_term_type;

   typedef enum logic [2:0] {
      BOOT_SAMPLE,
      BOOT_EE_REQ,
      BOOT_EE_LOAD,
      BOOT_HOST_WAIT,
      BOOT_RUN
   } boot_state_type;

endpackage

// File: rtl/pwr_link_if.sv
`timescale 1ns/100ps
`default_nettype none

interface pwr_link_if;
   import strap_boot_pkg::*;
   logic          run;
   logic          activity;
   logic          attached;
   logic          standbyReq;
   pwr_state_type state;
   logic          modernStandby;

   modport ctrl (output run, output activity, output attached, output standbyReq,
                 input state, input modernStandby);
   modport mgr  (input run, input activity, input attached, input standbyReq,
                 output state, output modernStandby);
endinterface

`default_nettype wire

// File: rtl/power_state_ctrl.sv
`timescale 1ns/100ps
`default_nettype none

module power_state_ctrl
   import strap_boot_pkg::*;
#(
   parameter int IDLE_CYCLES = 25000
) (
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic rstn,
   input  wire logic clkEn,
   // Link to controller
   pwr_link_if.mgr   link
);

   localparam int CNT_W = $clog2(IDLE_CYCLES + 1);

   generate
      if (IDLE_CYCLES < 1) begin : g_bad
         $error("IDLE_CYCLES must be at least one");
      end
   endgenerate

   pwr_state_type     state_r;
   logic              standby_r;
   logic [CNT_W-1:0]  quiet_r;
   logic              quietDone;

   assign quietDone          = (quiet_r == CNT_W'(IDLE_CYCLES));
   assign link.state         = state_r;
   assign link.modernStandby = standby_r;

   // Quiet-period counter; any activity restarts it
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         quiet_r <= '0;
      end else if (clkEn) begin
         if (link.activity || state_r != PWR_ACTIVE) begin
            quiet_r <= '0;
         end else if (!quietDone) begin
            quiet_r <= quiet_r + 1'b1;
         end
      end
   end

   // One state at a time, moved automatically
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state_r <= PWR_ACTIVE;
      end else if (clkEn) begin
         case (state_r)
            PWR_ACTIVE: begin
               if (link.run && quietDone && !link.activity) begin
                  state_r <= PWR_IDLE;
               end
            end
            PWR_IDLE: begin
               if (link.activity) begin
                  state_r <= PWR_ACTIVE;
               end else if (!link.attached) begin
                  state_r <= PWR_SLEEP;
               end
            end
            PWR_SLEEP: begin
               // Attach detection stays alive here
               if (link.attached || link.activity) begin
                  state_r <= PWR_ACTIVE;
               end
            end
            default: state_r <= PWR_ACTIVE;
         endcase
      end
   end

   // Modern Standby only qualifies Idle
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         standby_r <= 1'b0;
      end else if (clkEn) begin
         standby_r <= (state_r == PWR_IDLE) && link.standbyReq && !link.activity;
      end
   end

endmodule

`default_nettype wire

// File: tb/strap_boot_config_power_states_properties.sv
`timescale 1ns/100ps
`default_nettype none

module strap_boot_config_power_states_properties
   import strap_boot_pkg::*;
#(
   parameter int IDLE_CYCLES = 8
) (
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rstn,
   // Boot side
   input  wire logic       strapValid,
   input  wire logic       eepromReq,
   input  wire logic [6:0] eepromAddr,
   input  wire logic [6:0] targetAddr,
   input  wire logic       targetAddrValid,
   input  wire logic [1:0] policy,
   input  wire logic [1:0] addrIndex,
   input  wire logic       configLoaded,
   input  wire logic       bootDone,
   input  wire logic       applicationMode,
   input  wire logic       pdEnable,
   // Activity
   input  wire logic       pdMsgIn,
   input  wire logic       ccChange,
   input  wire logic       gpioEvent,
   input  wire logic       i2cActivity,
   input  wire logic       voltageAlert,
   input  wire logic       faultAlert,
   input  wire logic       typecAttached,
   // Power side
   input  wire logic [1:0] powerState,
   input  wire logic       modernStandby,
   input  wire logic       source5vPath,
   input  wire logic       highVoltageSinkPath,
   input  wire logic       externalSinkPath,
   input  wire logic       cablePowerPath,
   input  wire logic [1:0] cc1Term,
   input  wire logic [1:0] cc2Term
);
   logic [1:0]  upCnt_r;
   logic [15:0] quietCnt_r;
   logic        busy;
   logic        sinkOn;

   assign busy = pdMsgIn | ccChange | gpioEvent | i2cActivity | voltageAlert | faultAlert;
   assign sinkOn = highVoltageSinkPath | externalSinkPath;

   // Outputs still show reset values for the first edges
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) upCnt_r <= 2'h0;
      else if (upCnt_r != 2'h3) upCnt_r <= upCnt_r + 2'h1;
   end

   // Saturates so a long run never wraps into a false quiet count
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) quietCnt_r <= 16'h0000;
      else if (busy) quietCnt_r <= 16'h0000;
      else if (quietCnt_r != 16'hFFFF) quietCnt_r <= quietCnt_r + 16'h0001;
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   chk_eeprom_addr: assert property (eepromReq |-> eepromAddr == 7'h50)
      else $error("eeprom request at wrong address");
   chk_strap_first: assert property ($rose(eepromReq) |-> $past(strapValid, 2))
      else $error("eeprom request before strap capture");
   chk_target_addr: assert property (targetAddrValid |-> targetAddr == {5'h08, addrIndex})
      else $error("target address wrong");
   chk_boot_done: assert property ($rose(bootDone) |-> configLoaded && targetAddrValid)
      else $error("boot done without load");
   chk_always_sink: assert property ((upCnt_r == 2'h3 && policy == POL_ALWAYS_SINK && $stable(policy)
      && !configLoaded) |-> sinkOn && !pdEnable)
      else $error("always sink paths wrong");
   chk_high_volt: assert property ((upCnt_r == 2'h3 && policy == POL_HIGH_VOLTAGE && $stable(policy)
      && !configLoaded) |-> sinkOn && applicationMode && pdEnable)
      else $error("high voltage policy wrong");
   chk_no_sink: assert property ((upCnt_r == 2'h3 && policy == POL_NO_SINK && $stable(policy)
      && !configLoaded) |-> !sinkOn && !pdEnable)
      else $error("no sink policy wrong");
   chk_early_idle: assert property (!bootDone |-> powerState == PWR_ACTIVE)
      else $error("left active before boot");
   chk_idle_quiet: assert property ((powerState == PWR_IDLE && $past(powerState) == PWR_ACTIVE)
      |-> quietCnt_r >= IDLE_CYCLES)
      else $error("idle entered too early");
   chk_sleep_attach: assert property ((powerState == PWR_SLEEP && typecAttached)
      |-> ##[1:4] powerState == PWR_ACTIVE)
      else $error("attach did not wake");
   chk_standby_idle: assert property ($rose(modernStandby) |-> powerState == PWR_IDLE)
      else $error("standby outside idle");
   chk_sleep_off: assert property ((powerState == PWR_SLEEP && $past(powerState) == PWR_SLEEP)
      |-> !(source5vPath | sinkOn | cablePowerPath) && cc1Term == CC_OPEN && cc2Term == CC_OPEN)
      else $error("paths on in sleep");
endmodule

bind strap_boot_config_power_states strap_boot_config_power_states_properties #(
   .IDLE_CYCLES(IDLE_CYCLES)
) chk_u (.*);

`default_nettype wire

// File: tb/cfg_partner_model.sv
`timescale 1ns/100ps
`default_nettype none

module cfg_partner_model (
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rstn,
   // Scenario controls
   input  wire logic       present,
   input  wire logic       slow,
   input  wire logic       failLoad,
   // Controller port engine
   input  wire logic       eepromReq,
   input  wire logic [6:0] eepromAddr,
   output logic            eepromAck,
   output logic            eepromNack,
   output logic            eepromDone,
   output logic            eepromFail,
   // Host loader
   output logic            hostLoadDone
);
   logic [2:0] phase_r;
   logic [3:0] cnt_r;
   logic       due;

   // Slow answers expose any fixed-latency assumption
   assign due = cnt_r >= (slow ? 4'h6 : 4'h1);

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         phase_r <= 3'h0;
         cnt_r <= 4'h0;
         {eepromAck, eepromNack, eepromDone, eepromFail, hostLoadDone} <= 5'h00;
      end else begin
         {eepromAck, eepromNack, eepromDone, eepromFail, hostLoadDone} <= 5'h00;
         if (!due) cnt_r <= cnt_r + 4'h1;
         case (phase_r)
            3'h0: begin
               cnt_r <= 4'h0;
               if (eepromReq && eepromAddr == 7'h50) phase_r <= 3'h1;
            end
            3'h1: if (due) begin
               eepromAck <= present;
               eepromNack <= !present;
               phase_r <= present ? 3'h2 : 3'h3;
               cnt_r <= 4'h0;
            end
            3'h2: if (due && !eepromReq) begin
               eepromDone <= !failLoad;
               eepromFail <= failLoad;
               phase_r <= failLoad ? 3'h3 : 3'h4;
               cnt_r <= 4'h0;
            end
            3'h3: if (due && !eepromReq) begin
               hostLoadDone <= 1'b1;
               phase_r <= 3'h4;
            end
            default: ;
         endcase
      end
   end
endmodule

`default_nettype wire

// File: tb/tb_strap_boot_config_power_states.sv
`timescale 1ns/100ps
`default_nettype none

module tb_strap_boot_config_power_states;
   import strap_boot_pkg::*;

   localparam int IDLE = 8;
   logic       clk_sys, rstn, clkEn, strapValid, present, slow, failLoad;
   logic [2:0] strapValueA, strapValueB;
   logic       eepromReq, eepromAck, eepromNack, eepromDone, eepromFail, hostLoadDone;
   logic [6:0] eepromAddr, targetAddr;
   logic       targetAddrValid, strapInvalid, configLoaded, bootDone, applicationMode, pdEnable;
   logic [1:0] policy, addrIndex, powerState, cc1Term, cc2Term;
   logic [5:0] act;
   wire logic  pdMsgIn, ccChange, gpioEvent, i2cActivity, voltageAlert, faultAlert;
   logic       typecAttached, standbyReq, sourceRole, modernStandby;
   logic       source5vPath, highVoltageSinkPath, externalSinkPath, cablePowerPath;
   int         n_errors, n_checks;
   logic [5:0] pairs [12] = '{6'h3D, 6'h2D, 6'h10, 6'h0F, 6'h3B, 6'h1B, 6'h20, 6'h1F,
                              6'h38, 6'h00, 6'h30, 6'h2F};

   assign {faultAlert, voltageAlert, i2cActivity, gpioEvent, ccChange, pdMsgIn} = act;

   strap_boot_config_power_states #(.IDLE_CYCLES(IDLE)) dut_u (.*);
   cfg_partner_model part_u (.*);

   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   task automatic check(input logic [6:0] seen, input logic [6:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic final_report();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic boot(input logic [5:0] pair, input logic pres, input logic slw, input logic fl);
      @(posedge clk_sys);
      rstn <= 1'b0;
      strapValid <= 1'b0;
      present <= pres;
      slow <= slw;
      failLoad <= fl;
      {strapValueA, strapValueB} <= pair;
      @(negedge clk_sys);
      check({bootDone, eepromReq, pdEnable, policy}, 7'h00);
      repeat (10) @(posedge clk_sys);
      rstn <= 1'b1;
      strapValid <= 1'b1;
   endtask

   task automatic waitState(input logic [1:0] st, input int lim);
      for (int k = 0; k < lim && powerState !== st; k++) @(negedge clk_sys);
      check(powerState, st);
   endtask

   initial begin
      logic [1:0] pol;
      logic [1:0] idx;
      logic       pres;
      {rstn, strapValid, strapValueA, strapValueB, present, slow, failLoad} = '0;
      {act, typecAttached, standbyReq, sourceRole} = '0;
      clkEn = 1'b1;
      n_errors = 0;
      n_checks = 0;
      for (int i = 0; i < 13; i++) begin
         pol = (i < 12) ? 2'(i / 4) : 2'h2;
         idx = (i < 12) ? 2'(i % 4) : 2'h0;
         // No EEPROM under high-voltage policy, nor on odd-numbered passes
         pres = (pol != 2'h1) && (i % 2 == 0);
         boot((i < 12) ? pairs[i] : 6'h3F, pres, i % 3 == 0, i % 4 == 2);
         for (int k = 0; k < 20 && eepromReq !== 1'b1; k++) @(negedge clk_sys);
         check(policy, pol);
         check(addrIndex, idx);
         check(strapInvalid, i == 12);
         check(highVoltageSinkPath | externalSinkPath, pol != 2'h2);
         check(pdEnable, pol == 2'h1);
         check(applicationMode, pol == 2'h1);
         check(eepromAddr, 7'h50);
         for (int k = 0; k < 60 && bootDone !== 1'b1; k++) @(negedge clk_sys);
         check({bootDone, configLoaded, targetAddrValid}, 7'h07);
         check(targetAddr, {5'h08, idx});
      end
      @(posedge clk_sys);
      typecAttached <= 1'b1;
      // Each activity source must restart the quiet period
      for (int j = 0; j < 6; j++) begin
         repeat (5) @(posedge clk_sys);
         @(negedge clk_sys);
         check(powerState, PWR_ACTIVE);
         @(posedge clk_sys);
         act <= 6'h01 << j;
         @(posedge clk_sys);
         act <= 6'h00;
      end
      waitState(PWR_IDLE, 20);
      check({highVoltageSinkPath | externalSinkPath, cablePowerPath, source5vPath}, 7'h06);
      check(cc1Term, CC_RP_3A0);
      @(posedge clk_sys);
      standbyReq <= 1'b1;
      repeat (4) @(negedge clk_sys);
      check({modernStandby, powerState}, {5'h01, PWR_IDLE});
      check({highVoltageSinkPath | externalSinkPath, cablePowerPath, cc1Term}, 7'h00);
      @(posedge clk_sys);
      standbyReq <= 1'b0;
      typecAttached <= 1'b0;
      waitState(PWR_SLEEP, 30);
      check({source5vPath, highVoltageSinkPath, externalSinkPath, cablePowerPath}, 7'h00);
      check({cc1Term, cc2Term}, 7'h00);
      @(posedge clk_sys);
      typecAttached <= 1'b1;
      waitState(PWR_ACTIVE, 6);
      @(posedge clk_sys);
      sourceRole <= 1'b1;
      repeat (3) @(negedge clk_sys);
      check({source5vPath, highVoltageSinkPath | externalSinkPath, cablePowerPath}, 7'h05);
      check(cc1Term, CC_RD);
      // Enable low must freeze the path outputs
      @(posedge clk_sys);
      clkEn <= 1'b0;
      sourceRole <= 1'b0;
      repeat (3) @(negedge clk_sys);
      check(source5vPath, 1'b1);
      final_report();
   end

   // Whole run is well under 2000 cycles
   initial begin
      #(40 * 4000);
      n_errors++;
      final_report();
   end
endmodule

`default_nettype wire
